// ==== board_port_pkg.sv ====
// Package with I/O addresses, command fields and reset values for the board port block
package board_port_pkg;
  // Host I/O byte addresses
  localparam logic [7:0] PORT_A_ADDR        = 8'h0c8;
  localparam logic [7:0] PORT_B_ADDR        = 8'h0ca;
  localparam logic [7:0] PORT_C_ADDR        = 8'h0cc;
  localparam logic [7:0] PORT_C_BIT_COMMAND = 8'h0ce;
  localparam logic [7:0] ADDRESS_MODE_LATCH = 8'h0e4;
  localparam logic [7:0] PARITY_ERROR_CLEAR = 8'h0e8;
  // Control word fields
  localparam int CMD_MODE_SET_POS = 7;
  localparam int CMD_SEL_MSB      = 3;
  localparam int CMD_SEL_LSB      = 1;
  localparam int CMD_VALUE_POS    = 0;
  localparam int CMD_PORT_A_IN    = 4;
  localparam int MODE_SELECT_POS  = 0;
  // Port C bit positions
  localparam int STROBE_DRIVE_BIT       = 0;
  localparam int SHARED_MEMORY_LOCK_BIT = 1;
  localparam int NMI_MASK_BIT           = 2;
  localparam int BUS_TIMEOUT_ENABLE_BIT = 3;
  localparam int USER_INTR_LATCH_BIT    = 4;
  localparam int BUS_INTR_DRIVE_ONE     = 5;
  localparam int BUS_INTR_DRIVE_TWO     = 6;
  localparam int PRINTER_INTR_ENABLE_BIT = 7;
  // Reset values
  localparam logic [7:0] PORT_C_RESET  = 8'h00;
  localparam logic [7:0] PORT_A_RESET  = 8'h00;
  localparam logic       MODE_RESET    = 1'b0;
  localparam logic       PORT_A_OUT_RESET = 1'b0;
  // Unmapped or write-only reads
  localparam logic [7:0] READ_IDLE = 8'h00;
  // Printer status bit positions on port B
  localparam int STAT_BUSY_POS  = 0;
  localparam int STAT_ACK_POS   = 1;
  localparam int STAT_FAULT_POS = 2;
endpackage

// ==== pin_sync.sv ====
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic rst_val_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    s1_reg <= pin_i;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // Change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= rst_val_i;
    end else if (s2_reg == s3_reg) begin
      level_o <= s3_reg;
    end
  end
endmodule

// ==== board_port.sv ====
// Port C bit control, printer port, parity clear and address mode latch
// Notes on behaviour
// [RL1] Control byte 0000xxxx: bits 3..1 pick a port C bit, bit 0 its value.
// [RL2] Printer strobe idles high, low while the strobe drive bit is set.
// [RL3] NMI mask bit set blocks the NMI request; clear lets it pass.
// [RL4] Time-out enable bit set enables the time-out interrupt; clear clears and holds it.
// [RL5] User latch bit set enables user latch and lights LED two; clear clears both.
// [RL6] Bus interrupt drive bits set pull their active-low bus lines low.
// [RL7] Printer enable bit set enables latch and LED four; clear clears latch.
// [RL8] Printer data bus is driven from port A when port A is an output.
// [RL9] Printer holds busy low when it can take data, high otherwise.
// [RL10] Printer drives acknowledge low when it has taken the byte.
// [RL11] Printer raises fault when it needs operator attention.
// [RL12] Host places data, pulses strobe low, then waits for busy low.
// [RL13] Printer raises busy, pulses acknowledge, then drops busy.
// [RL14] Driver reads port B status: busy 0 and acknowledge 1 before writing.
// [RL15] Enabled acknowledge sets printer latch, which requests slave level 7.
// [RL16] Service clears the printer enable bit, sets it after the next strobe.
// [RL17] Any byte write to parity clear address clears the parity error latch.
// [RL18] Host clears parity and masks NMI around uninitialised memory access.
// [RL19] Byte write with mode bit 1 to mode address selects protected mode.
// [RL20] Mode address reads mode bit; a write with bit 0 returns to real mode.
// [RL21] Word write to port B address also sets protected mode, no port effect.
// [RL22] After power-up the address mode latch shows real mode.
// [RL23] After reset the port comes up in basic mode, all ports inputs; here only port A goes to input, port C keeps driving its latches, reset to 00.
// [RL24] A bit command changes only the chosen port C bit.
// [RL25] Time-out events are ignored while the time-out enable bit is clear.
`timescale 1ns/100ps
module board_port (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Host I/O access
  input  wire logic [7:0] io_addr_i,
  input  wire logic [7:0] io_wdata_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_rd_i,
  input  wire logic       io_word_i,
  output logic      [7:0] io_rdata_o,
  // Board inputs
  input  wire logic [2:0] user_code_i,
  input  wire logic       nmi_request_i,
  input  wire logic       bus_timeout_event_i,
  input  wire logic       user_intr_set_i,
  input  wire logic       parity_error_i,
  // Printer pins
  input  wire logic       printer_busy_in,
  input  wire logic       printer_ack_n,
  input  wire logic       printer_fault_in,
  output logic      [7:0] printer_data_out,
  output logic            printer_data_oe_o,
  output logic            printer_strobe_n,
  // Board outputs
  output logic            shared_memory_lock_n_o,
  output logic            nmi_o,
  output logic            bus_timeout_intr_o,
  output logic            user_intr_latch_out,
  output logic            user_led_two,
  output logic            user_led_four,
  output logic            bus_intr_one_n_o,
  output logic            bus_intr_two_n_o,
  output logic            printer_intr_latch_out,
  output logic            parity_intr_o,
  output logic            protected_mode_o
);
  logic [7:0] port_c_reg;
  logic [7:0] port_a_reg;
  logic       port_a_out_reg;
  logic       mode_reg;
  logic       timeout_intr_reg;
  logic       timeout_prev_reg;
  logic       user_latch_reg;
  logic       printer_latch_reg;
  logic       parity_latch_reg;
  logic       busy_s;
  logic       ack_n_s;
  logic       fault_s;
  logic       timeout_s;
  logic       cmd_wr;
  logic       bitcmd_wr;
  logic       mode_wr;
  logic       port_a_wr;
  logic       port_c_wr;
  logic       parity_wr;
  logic       protect_word_wr;
  logic [2:0] bit_sel;
  logic [7:0] status_word;

  // Printer pins and the bus time-out event pass the synchroniser
  pin_sync busy_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .rst_val_i (1'b0),
    .pin_i     (printer_busy_in),
    .level_o   (busy_s)
  );
  pin_sync ack_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .rst_val_i (1'b1),
    .pin_i     (printer_ack_n),
    .level_o   (ack_n_s)
  );
  pin_sync fault_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .rst_val_i (1'b0),
    .pin_i     (printer_fault_in),
    .level_o   (fault_s)
  );
  pin_sync timeout_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .rst_val_i (1'b0),
    .pin_i     (bus_timeout_event_i),
    .level_o   (timeout_s)
  );

  // Address decode; byte accesses only except the port B word write
  // Word accesses elsewhere are dropped, so a stray word write cannot hit a latch
  always_comb begin
    cmd_wr          = 1'b0;
    mode_wr         = 1'b0;
    port_a_wr       = 1'b0;
    port_c_wr       = 1'b0;
    parity_wr       = 1'b0;
    protect_word_wr = 1'b0;
    if (io_wr_i && io_word_i) begin
      protect_word_wr = (io_addr_i == board_port_pkg::PORT_B_ADDR); // [RL21]
    end else if (io_wr_i) begin
      unique case (io_addr_i)
        board_port_pkg::PORT_C_BIT_COMMAND: begin
          cmd_wr = 1'b1;
        end
        board_port_pkg::ADDRESS_MODE_LATCH: begin
          mode_wr = 1'b1;
        end
        board_port_pkg::PORT_A_ADDR: begin
          port_a_wr = 1'b1;
        end
        board_port_pkg::PORT_C_ADDR: begin
          port_c_wr = 1'b1;
        end
        board_port_pkg::PARITY_ERROR_CLEAR: begin
          parity_wr = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end
  assign bitcmd_wr = cmd_wr && !io_wdata_i[board_port_pkg::CMD_MODE_SET_POS]; // [RL1]
  assign bit_sel   = io_wdata_i[board_port_pkg::CMD_SEL_MSB:board_port_pkg::CMD_SEL_LSB];

  // Port C output latches, one per bit so a command touches only its own
  for (genvar i = 0; i < 8; i++) begin : g_port_c
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        port_c_reg[i] <= board_port_pkg::PORT_C_RESET[i]; // [RL23]
      end else if (bitcmd_wr && (bit_sel == 3'(i))) begin
        port_c_reg[i] <= io_wdata_i[board_port_pkg::CMD_VALUE_POS]; // [RL1] [RL24]
      end else if (port_c_wr) begin
        port_c_reg[i] <= io_wdata_i[i];
      end
    end
  end

  // Port B status word for polling; bits 4:3 read zero
  always_comb begin
    status_word                                 = {user_code_i, 5'h00};
    status_word[board_port_pkg::STAT_BUSY_POS]  = busy_s;
    status_word[board_port_pkg::STAT_ACK_POS]   = ack_n_s; // [RL14]
    status_word[board_port_pkg::STAT_FAULT_POS] = fault_s;
  end

  // Mode set word: only port A direction is meaningful, always mode 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_a_out_reg <= board_port_pkg::PORT_A_OUT_RESET; // [RL23]
    end else if (cmd_wr && io_wdata_i[board_port_pkg::CMD_MODE_SET_POS]) begin
      port_a_out_reg <= !io_wdata_i[board_port_pkg::CMD_PORT_A_IN];
    end
  end

  // Port A data latch; a word write to port B never reaches it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_a_reg <= board_port_pkg::PORT_A_RESET;
    end else if (port_a_wr) begin
      port_a_reg <= io_wdata_i;
    end
  end

  // Printer data follows port A only while port A is an output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      printer_data_out <= board_port_pkg::PORT_A_RESET;
    end else begin
      printer_data_out <= port_a_out_reg ? port_a_reg : board_port_pkg::PORT_A_RESET; // [RL8]
    end
  end
  assign printer_data_oe_o = port_a_out_reg; // [RL8]

  // Strobe timing is software paced: data, strobe, wait for busy low
  assign printer_strobe_n = !port_c_reg[board_port_pkg::STROBE_DRIVE_BIT]; // [RL2] [RL12]

  assign shared_memory_lock_n_o = port_c_reg[board_port_pkg::SHARED_MEMORY_LOCK_BIT];
  // Masking gates the request so uninitialised memory reads stay quiet
  assign nmi_o = nmi_request_i && !port_c_reg[board_port_pkg::NMI_MASK_BIT]; // [RL3] [RL18]
  assign bus_intr_one_n_o = !port_c_reg[board_port_pkg::BUS_INTR_DRIVE_ONE]; // [RL6]
  assign bus_intr_two_n_o = !port_c_reg[board_port_pkg::BUS_INTR_DRIVE_TWO]; // [RL6]
  assign user_led_two  = port_c_reg[board_port_pkg::USER_INTR_LATCH_BIT]; // [RL5]
  assign user_led_four = port_c_reg[board_port_pkg::PRINTER_INTR_ENABLE_BIT]; // [RL7]

  // Time-out latch sets on a rising event, held clear while disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_prev_reg <= 1'b0;
    end else begin
      timeout_prev_reg <= timeout_s;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_intr_reg <= 1'b0;
    end else if (!port_c_reg[board_port_pkg::BUS_TIMEOUT_ENABLE_BIT]) begin
      timeout_intr_reg <= 1'b0; // [RL4] [RL25]
    end else if (timeout_s && !timeout_prev_reg) begin
      timeout_intr_reg <= 1'b1; // [RL4]
    end
  end
  assign bus_timeout_intr_o = timeout_intr_reg;

  // User latch: clear bit low forces zero, set input latches one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      user_latch_reg <= 1'b0;
    end else if (!port_c_reg[board_port_pkg::USER_INTR_LATCH_BIT]) begin
      user_latch_reg <= 1'b0; // [RL5]
    end else if (user_intr_set_i) begin
      user_latch_reg <= 1'b1; // [RL5]
    end
  end
  assign user_intr_latch_out = user_latch_reg;

  // Printer latch: disabled clears it, acknowledge low sets it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      printer_latch_reg <= 1'b0;
    end else if (!port_c_reg[board_port_pkg::PRINTER_INTR_ENABLE_BIT]) begin
      printer_latch_reg <= 1'b0; // [RL7] [RL16]
    end else if (!ack_n_s) begin
      printer_latch_reg <= 1'b1; // [RL15]
    end
  end
  // Routed to slave controller level 7 outside this block
  assign printer_intr_latch_out = printer_latch_reg; // [RL15]

  // Parity latch: a new error in the clear cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      parity_latch_reg <= 1'b0;
    end else if (parity_error_i) begin
      parity_latch_reg <= 1'b1;
    end else if (parity_wr) begin
      parity_latch_reg <= 1'b0; // [RL17] [RL18]
    end
  end
  assign parity_intr_o = parity_latch_reg;

  // Address mode latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= board_port_pkg::MODE_RESET; // [RL22]
    end else if (protect_word_wr) begin
      mode_reg <= 1'b1; // [RL21]
    end else if (mode_wr) begin
      mode_reg <= io_wdata_i[board_port_pkg::MODE_SELECT_POS]; // [RL19] [RL20]
    end
  end
  assign protected_mode_o = mode_reg;

  // Read data registered; port B carries printer status for polling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_rdata_o <= board_port_pkg::READ_IDLE;
    end else if (io_rd_i) begin
      unique case (io_addr_i)
        board_port_pkg::PORT_A_ADDR: begin
          io_rdata_o <= port_a_out_reg ? port_a_reg : board_port_pkg::READ_IDLE;
        end
        board_port_pkg::PORT_B_ADDR: begin
          io_rdata_o <= status_word; // [RL14]
        end
        board_port_pkg::PORT_C_ADDR: begin
          io_rdata_o <= port_c_reg;
        end
        board_port_pkg::ADDRESS_MODE_LATCH: begin
          io_rdata_o <= {7'h00, mode_reg}; // [RL20]
        end
        default: begin
          io_rdata_o <= board_port_pkg::READ_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== board_port_monitor.sv ====
// Checker bound to the board port top
`timescale 1ns/100ps
module board_port_monitor (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic       io_wr_i,
  input wire logic       io_word_i,
  input wire logic       parity_error_i,
  input wire logic       nmi_o,
  input wire logic       printer_strobe_n,
  input wire logic       printer_data_oe_o,
  input wire logic       bus_timeout_intr_o,
  input wire logic       user_intr_latch_out,
  input wire logic       user_led_two,
  input wire logic       user_led_four,
  input wire logic       bus_intr_one_n_o,
  input wire logic       printer_intr_latch_out,
  input wire logic       parity_intr_o,
  input wire logic       protected_mode_o
);
  wire cw = io_wr_i && io_addr_i == 8'hce;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_stb; cw && io_wdata_i == 8'h01 |=> !printer_strobe_n; endproperty
  a_stb: assert property (p_stb) else $error("strobe not low");
  property p_nmi; cw && io_wdata_i == 8'h05 |=> !nmi_o; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not masked");
  property p_tmo; cw && io_wdata_i == 8'h06 |=> ##1 !bus_timeout_intr_o [*2]; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout not held off");
  // Latches clear one cycle after the port C bit drops
  property p_usr; cw && io_wdata_i == 8'h08 |=> !user_led_two ##1 !user_intr_latch_out;
  endproperty
  a_usr: assert property (p_usr) else $error("user latch not cleared");
  property p_bus; cw && io_wdata_i == 8'h0b |=> !bus_intr_one_n_o && $stable(printer_strobe_n);
  endproperty
  a_bus: assert property (p_bus) else $error("bus line or other bit wrong");
  property p_lpt; cw && io_wdata_i == 8'h0e |=> !user_led_four ##1 !printer_intr_latch_out;
  endproperty
  a_lpt: assert property (p_lpt) else $error("printer latch not cleared");
  property p_ack; $rose(printer_intr_latch_out) |-> $past(user_led_four); endproperty
  a_ack: assert property (p_ack) else $error("printer latch set while disabled");
  property p_par; io_wr_i && io_addr_i == 8'he8 && !parity_error_i |=> !parity_intr_o; endproperty
  a_par: assert property (p_par) else $error("parity not cleared");
  property p_mode; io_wr_i && io_addr_i == 8'he4 |=> protected_mode_o == $past(io_wdata_i[0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode latch wrong");
  property p_word; io_wr_i && io_word_i && io_addr_i == 8'hca |=> protected_mode_o; endproperty
  a_word: assert property (p_word) else $error("word write missed");
  // Reset itself is the cause here, so no disable
  property p_rst; disable iff (1'b0)
    rst_i |=> !protected_mode_o && printer_strobe_n && !printer_data_oe_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind board_port board_port_monitor u_mon (.clk_i, .rst_i, .io_addr_i, .io_wdata_i, .io_wr_i,
  .io_word_i, .parity_error_i, .nmi_o, .printer_strobe_n, .printer_data_oe_o, .bus_timeout_intr_o,
  .user_intr_latch_out, .user_led_two, .user_led_four, .bus_intr_one_n_o,
  .printer_intr_latch_out, .parity_intr_o, .protected_mode_o);

// ==== printer_model.sv ====
// Behavioural printer on the far side of the port
`timescale 1ns/100ps
module printer_model (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] data_i,
  input  wire logic       strobe_n_i,
  output logic            busy_o,
  output logic            ack_n_o,
  output logic      [7:0] got_o
);
  int k;
  initial begin
    busy_o = 1'b0;
    ack_n_o = 1'b1;
    got_o = 8'h00;
    forever begin
      @(negedge strobe_n_i);
      got_o = data_i;
      k = slow_i ? 10 : 1;
      repeat (k * 4) @(posedge clk_i);
      busy_o <= 1'b1;
      repeat (k * 8) @(posedge clk_i);
      ack_n_o <= 1'b0;
      // Wide enough to pass the pin filter
      repeat (6) @(posedge clk_i);
      ack_n_o <= 1'b1;
      repeat (k * 4) @(posedge clk_i);
      busy_o <= 1'b0;
    end
  end
endmodule

// ==== tb.sv ====
// Self-checking bench for the board port block
`timescale 1ns/100ps
module tb;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [7:0] io_addr_i = 8'h00;
  logic [7:0] io_wdata_i = 8'h00;
  logic       io_wr_i = 1'b0;
  logic       io_rd_i = 1'b0;
  logic       io_word_i = 1'b0;
  logic [2:0] user_code_i = 3'h0;
  logic       nmi_request_i = 1'b1;
  logic       bus_timeout_event_i = 1'b0;
  logic       user_intr_set_i = 1'b0;
  logic       parity_error_i = 1'b0;
  logic       printer_fault_in = 1'b0;
  logic       slow = 1'b0;
  logic       printer_busy_in, printer_ack_n, printer_data_oe_o, printer_strobe_n, nmi_o;
  logic       shared_memory_lock_n_o, bus_timeout_intr_o, user_intr_latch_out, user_led_two;
  logic       user_led_four, bus_intr_one_n_o, bus_intr_two_n_o, printer_intr_latch_out;
  logic       parity_intr_o, protected_mode_o;
  logic [7:0] io_rdata_o, printer_data_out, got, st, d;
  logic [7:0] pc_m = 8'h00;
  int         bad_count = 0;
  int         samples_checked = 0;
  wire  [7:0] lat = {5'h00, bus_timeout_intr_o, user_intr_latch_out, parity_intr_o};
  board_port u_dut (.clk_i, .rst_i, .io_addr_i, .io_wdata_i, .io_wr_i, .io_rd_i, .io_word_i,
    .io_rdata_o, .user_code_i, .nmi_request_i, .bus_timeout_event_i, .user_intr_set_i,
    .parity_error_i, .printer_busy_in, .printer_ack_n, .printer_fault_in, .printer_data_out,
    .printer_data_oe_o, .printer_strobe_n, .shared_memory_lock_n_o, .nmi_o, .bus_timeout_intr_o,
    .user_intr_latch_out, .user_led_two, .user_led_four, .bus_intr_one_n_o, .bus_intr_two_n_o,
    .printer_intr_latch_out, .parity_intr_o, .protected_mode_o);
  printer_model u_prn (.clk_i, .slow_i(slow), .data_i(printer_data_out),
    .strobe_n_i(printer_strobe_n), .busy_o(printer_busy_in), .ack_n_o(printer_ack_n), .got_o(got));
  initial forever #2 clk_i = ~clk_i;
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic w);
    @(posedge clk_i);
    io_addr_i <= a;
    io_wdata_i <= v;
    io_wr_i <= 1'b1;
    io_word_i <= w;
    @(posedge clk_i);
    io_wr_i <= 1'b0;
    io_word_i <= 1'b0;
    if (a == 8'hce && !v[7]) pc_m[v[3:1]] = v[0];
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    io_addr_i <= a;
    io_rd_i <= 1'b1;
    @(posedge clk_i);
    io_rd_i <= 1'b0;
    @(negedge clk_i);
    st = io_rdata_o;
  endtask
  // Bit 3 has no direct pin, so the model value stands in
  task automatic chk_pc;
    cmp("port_c", pc_m, {user_led_four, ~bus_intr_two_n_o, ~bus_intr_one_n_o, user_led_two,
      pc_m[3], ~nmi_o, shared_memory_lock_n_o, ~printer_strobe_n});
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_i);
    {bus_timeout_event_i, user_intr_set_i, parity_error_i} <= m;
    repeat (6) @(posedge clk_i);
    {bus_timeout_event_i, user_intr_set_i, parity_error_i} <= 3'b000;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(34428));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    user_code_i <= 3'($urandom);
    printer_fault_in <= 1'($urandom);
    rd(8'he4);
    cmp("mode", 8'h00, st);
    cmp("oe", 8'h00, {7'h00, printer_data_oe_o});
    chk_pc();
    for (int i = 0; i < 48; i++) begin
      d = (i < 16) ? 8'(i) : {4'h0, 4'($urandom)};
      wr(8'hce, d, 1'b0);
      chk_pc();
    end
    wr(8'hce, 8'h00, 1'b0);
    wr(8'hce, 8'h06, 1'b0);
    wr(8'hce, 8'h08, 1'b0);
    pulse(3'b111);
    cmp("latch", 8'h01, lat);
    wr(8'he8, 8'($urandom), 1'b0);
    cmp("latch", 8'h00, lat);
    wr(8'hce, 8'h07, 1'b0);
    wr(8'hce, 8'h09, 1'b0);
    pulse(3'b110);
    cmp("latch", 8'h06, lat);
    wr(8'hce, 8'h06, 1'b0);
    wr(8'hce, 8'h08, 1'b0);
    @(negedge clk_i);
    cmp("latch", 8'h00, lat);
    for (int j = 0; j < 3; j++) begin
      wr(j[1] ? 8'hca : 8'he4, j[0] ? 8'hfe : 8'h01, j[1]);
      rd(8'he4);
      cmp("mode", {7'h00, ~j[0]}, st);
    end
    wr(8'hce, 8'h82, 1'b0);
    for (int b = 0; b < 3; b++) begin
      slow <= (b == 1);
      wr(8'hce, 8'h0e, 1'b0);
      @(negedge clk_i);
      cmp("printer_intr_latch_out", 8'h00, {7'h00, printer_intr_latch_out});
      st = 8'h00;
      for (int t = 0; t < 100 && st[1:0] !== 2'b10; t++) rd(8'hca);
      cmp("status", {user_code_i, 2'b00, printer_fault_in, 2'b10}, st);
      d = 8'($urandom);
      wr(8'hc8, d, 1'b0);
      @(negedge clk_i);
      cmp("data", d, printer_data_out);
      wr(8'hce, 8'h01, 1'b0);
      wr(8'hce, 8'h00, 1'b0);
      wr(8'hce, 8'h0f, 1'b0);
      for (int t = 0; t < 300 && printer_intr_latch_out !== 1'b1; t++) @(negedge clk_i);
      cmp("printer_intr_latch_out", 8'h01, {7'h00, printer_intr_latch_out});
      cmp("byte", d, got);
    end
    end_of_test();
  end
endmodule
